/* hw/pdmc_pkg.sv */
// Purpose: Constants and types for the power-down mode controller
// Assumes: 8-bit register port, one clock
// Notes: Offsets are byte addresses of the register space
package pdmc_pkg;
	localparam logic [7:0] ADDR_OSC_SELECT = 8'hd3;
	localparam logic [7:0] ADDR_CLK_DIV = 8'hd4;
	localparam logic [7:0] ADDR_BT_CTRL = 8'hdc;
	localparam logic [7:0] ADDR_BT_COUNT = 8'hdd;
	localparam logic [7:0] ADDR_STOP_KEY = 8'he0;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'he1;
	localparam logic [7:0] ADDR_STATUS = 8'he2;
	localparam logic [7:0] STOP_KEY_VALUE = 8'ha5;
	localparam logic [7:0] OPC_IDLE = 8'h6f;
	localparam logic [7:0] OPC_STOP = 8'h7f;
	localparam logic [7:0] RST_OSC_SELECT = 8'h00;
	localparam logic [7:0] RST_CLK_DIV = 8'h00;
	localparam logic [7:0] RST_BT_CTRL = 8'h00;
	localparam logic [7:0] RST_STOP_KEY = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK = 8'h00;
	localparam logic [15:0] RESET_VECTOR = 16'h0100;
	localparam int OSC_SYS_SUB_BIT = 0;
	localparam int OSC_SUB_STOP_BIT = 2;
	localparam int OSC_MAIN_STOP_BIT = 3;
	localparam int DIV_LO_BIT = 3;
	localparam int DIV_HI_BIT = 4;
	localparam int BT_STAB_LO_BIT = 2;
	localparam int BT_STAB_HI_BIT = 3;
	localparam logic [1:0] DIV_BY_16 = 2'h0;
	localparam logic [1:0] DIV_BY_8 = 2'h1;
	localparam logic [1:0] DIV_BY_2 = 2'h2;
	localparam logic [1:0] DIV_BY_1 = 2'h3;
	localparam logic [3:0] DIV_CNT_16 = 4'hf;
	localparam logic [3:0] DIV_CNT_8 = 4'h7;
	localparam logic [3:0] DIV_CNT_2 = 4'h1;
	localparam logic [3:0] DIV_CNT_1 = 4'h0;
	localparam logic [7:0] STAB_CYC_0 = 8'h10;
	localparam logic [7:0] STAB_CYC_1 = 8'h20;
	localparam logic [7:0] STAB_CYC_2 = 8'h40;
	localparam logic [7:0] STAB_CYC_3 = 8'h80;
	typedef enum logic [1:0] {
		PDMC_RUN = 2'b00,
		PDMC_STOP = 2'b01,
		PDMC_IDLE = 2'b10,
		PDMC_WAKE = 2'b11
	} pdmc_state_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pdmc_bus_t;
	typedef struct packed {
		logic cpu_clk_en;
		logic periph_clk_en;
		logic idle_periph_clk_en;
		logic main_osc_run;
		logic sub_osc_run;
		logic watch_lcd_en;
	} pdmc_gate_t;
endpackage

/* hw/pdmc_controller.sv */
// Purpose: Stop and Idle power-down mode controller of an 8-bit microcontroller
// Assumes: CPU core decodes instructions and services interrupts; inputs synchronous
// Notes: Clock gates are enables for the clock tree, not gated clocks
// What this block does
// - Stop instruction halts CPU, main oscillator and main-clocked peripherals.
// - Watch timer and LCD keep running in Stop when sub-clocked.
// - Register file contents stay unchanged while in Stop.
// - Stop ends on reset, sub-clocked watch timer interrupt, or external interrupt.
// - Stop honoured only while the key register holds 10100101B.
// - Reset out of Stop restores control registers, fetch starts at 0100H.
// - Reset out of Idle restores control registers, selecting divide by 16.
// - With sub clock as system clock only reset ends Stop.
// - Interrupt release of Stop leaves all control registers untouched.
// - Interrupt release of Stop keeps the clock divider field.
// - Waking interrupt is serviced first, then execution continues after stop.
// - Idle opcode 6FH enters Idle mode, halting CPU execution.
// - Idle gates clock from CPU and all but the listed peripherals.
// - I/O directions hold throughout Idle mode.
// - With all external interrupts masked, only reset ends Idle.
// - Enabled interrupt ends Idle, divider kept, resume after idle.
// - Reset clears the divider control register at D4H.
// - Divider field divides selected clock by 1, 2, 8 or 16.
// - Stop wake-up delay set by basic timer control register.
// - Oscillator select: bit 0 system clock, bit 3 main, bit 2 sub.
`timescale 1ns/1ps
`default_nettype none
module pdmc_controller (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_unused_in,
	input wire logic opcode_valid_in,
	input wire logic [7:0] opcode_in,
	input wire logic [7:0] ext_irq_in,
	input wire logic watch_irq_in,
	input wire logic internal_irq_in,
	input wire logic watch_sub_clk_in,
	input wire logic [7:0] io_dir_in,
	output logic [7:0] reg_rdata_out,
	output logic cpu_clk_en_out,
	output logic periph_clk_en_out,
	output logic idle_periph_clk_en_out,
	output logic main_osc_run_out,
	output logic sub_osc_run_out,
	output logic watch_lcd_en_out,
	output logic cpu_tick_out,
	output logic regfile_hold_out,
	output logic [7:0] io_dir_out,
	output logic io_dir_hold_out,
	output logic wake_irq_out,
	output logic fetch_reset_out,
	output logic [15:0] fetch_addr_out,
	output logic [1:0] mode_out
);
	pdmc_pkg::pdmc_bus_t bus;
	pdmc_pkg::pdmc_gate_t gate, next_gate;
	pdmc_pkg::pdmc_state_t state, next_state;
	logic [7:0] oscillator_select_control;
	logic [7:0] cpu_clock_divider_control;
	logic [7:0] basic_timer_control;
	logic [7:0] basic_timer_count;
	logic [7:0] stop_key_register;
	logic [7:0] interrupt_mask_register;
	logic [7:0] stab_count;
	logic [3:0] div_count;
	logic [7:0] io_dir_latched;
	logic first_cycle;

	function automatic logic [3:0] div_limit(input logic [1:0] sel);
		case (sel)
			pdmc_pkg::DIV_BY_16: div_limit = pdmc_pkg::DIV_CNT_16;
			pdmc_pkg::DIV_BY_8: div_limit = pdmc_pkg::DIV_CNT_8;
			pdmc_pkg::DIV_BY_2: div_limit = pdmc_pkg::DIV_CNT_2;
			default: div_limit = pdmc_pkg::DIV_CNT_1;
		endcase
	endfunction

	function automatic logic [7:0] stab_cycles(input logic [1:0] sel);
		case (sel)
			2'h0: stab_cycles = pdmc_pkg::STAB_CYC_0;
			2'h1: stab_cycles = pdmc_pkg::STAB_CYC_1;
			2'h2: stab_cycles = pdmc_pkg::STAB_CYC_2;
			default: stab_cycles = pdmc_pkg::STAB_CYC_3;
		endcase
	endfunction

	assign bus.addr = reg_addr_in;
	assign bus.wdata = reg_wdata_in;
	assign bus.wr = reg_wr_in;
	assign bus.rd = reg_rd_in;

	wire sys_on_sub = oscillator_select_control[pdmc_pkg::OSC_SYS_SUB_BIT];
	wire main_osc_off = oscillator_select_control[pdmc_pkg::OSC_MAIN_STOP_BIT];
	wire sub_osc_off = oscillator_select_control[pdmc_pkg::OSC_SUB_STOP_BIT];
	wire [1:0] div_sel = cpu_clock_divider_control[pdmc_pkg::DIV_HI_BIT:pdmc_pkg::DIV_LO_BIT];
	wire [1:0] stab_sel = basic_timer_control[pdmc_pkg::BT_STAB_HI_BIT:pdmc_pkg::BT_STAB_LO_BIT];
	wire key_ok = stop_key_register == pdmc_pkg::STOP_KEY_VALUE;
	wire stop_op = opcode_valid_in && opcode_in == pdmc_pkg::OPC_STOP;
	wire idle_op = opcode_valid_in && opcode_in == pdmc_pkg::OPC_IDLE;
	wire stop_go = stop_op && key_ok;
	wire ext_wake = |(ext_irq_in & interrupt_mask_register);
	wire watch_wake = watch_irq_in && watch_sub_clk_in;
	// Sub clock as system clock: interrupts cannot restart the halted system
	wire stop_wake = !sys_on_sub && (ext_wake || watch_wake);
	// A fully masked register leaves reset as the only way out of Idle
	wire idle_wake = ext_wake || (|interrupt_mask_register && (internal_irq_in || watch_irq_in));
	wire wr_osc = bus.wr && bus.addr == pdmc_pkg::ADDR_OSC_SELECT;
	wire wr_div = bus.wr && bus.addr == pdmc_pkg::ADDR_CLK_DIV;
	wire wr_bt = bus.wr && bus.addr == pdmc_pkg::ADDR_BT_CTRL;
	wire wr_key = bus.wr && bus.addr == pdmc_pkg::ADDR_STOP_KEY;
	wire wr_mask = bus.wr && bus.addr == pdmc_pkg::ADDR_IRQ_MASK;
	wire cpu_halted = state != pdmc_pkg::PDMC_RUN;
	wire div_wrap = div_count == div_limit(div_sel);
	logic [7:0] rd_mux;

	always_comb begin
		case (bus.addr)
			pdmc_pkg::ADDR_OSC_SELECT: rd_mux = oscillator_select_control;
			pdmc_pkg::ADDR_CLK_DIV: rd_mux = cpu_clock_divider_control;
			pdmc_pkg::ADDR_BT_CTRL: rd_mux = basic_timer_control;
			pdmc_pkg::ADDR_BT_COUNT: rd_mux = basic_timer_count;
			pdmc_pkg::ADDR_STOP_KEY: rd_mux = stop_key_register;
			pdmc_pkg::ADDR_IRQ_MASK: rd_mux = interrupt_mask_register;
			pdmc_pkg::ADDR_STATUS: rd_mux = {6'h00, state};
			default: rd_mux = 8'h00;
		endcase
	end

	always_comb begin
		next_state = state;
		case (state)
			pdmc_pkg::PDMC_RUN: begin
				if (stop_go) begin
					next_state = pdmc_pkg::PDMC_STOP;
				end else if (idle_op) begin
					next_state = pdmc_pkg::PDMC_IDLE;
				end
			end
			pdmc_pkg::PDMC_STOP: begin
				if (stop_wake) begin
					next_state = pdmc_pkg::PDMC_WAKE;
				end
			end
			pdmc_pkg::PDMC_IDLE: begin
				if (idle_wake) begin
					next_state = pdmc_pkg::PDMC_RUN;
				end
			end
			pdmc_pkg::PDMC_WAKE: begin
				if (stab_count == 8'h00) begin
					next_state = pdmc_pkg::PDMC_RUN;
				end
			end
			default: next_state = pdmc_pkg::PDMC_RUN;
		endcase
	end

	always_comb begin
		next_gate.cpu_clk_en = next_state == pdmc_pkg::PDMC_RUN;
		next_gate.periph_clk_en = next_state == pdmc_pkg::PDMC_RUN;
		next_gate.idle_periph_clk_en = next_state != pdmc_pkg::PDMC_STOP;
		next_gate.main_osc_run = !main_osc_off && next_state != pdmc_pkg::PDMC_STOP;
		next_gate.sub_osc_run = !sub_osc_off;
		next_gate.watch_lcd_en = next_state != pdmc_pkg::PDMC_STOP || watch_sub_clk_in;
	end

	assign gate = next_gate;

	// Status outputs are taken from next_state so they change on the same edge as the mode
	wire next_regfile_hold = next_state != pdmc_pkg::PDMC_RUN;
	wire next_io_dir_hold = next_state == pdmc_pkg::PDMC_IDLE;
	wire [7:0] next_io_dir = (state == pdmc_pkg::PDMC_RUN) ? io_dir_in : io_dir_latched;
	wire next_wake_irq = next_state == pdmc_pkg::PDMC_RUN && cpu_halted;
	wire [7:0] next_rdata = bus.rd ? rd_mux : 8'h00;
	wire next_cpu_tick = div_wrap && !cpu_halted;
	wire stop_release = state == pdmc_pkg::PDMC_STOP && stop_wake;

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			state <= pdmc_pkg::PDMC_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Control registers are written only by software, so wake-ups leave them alone
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			oscillator_select_control <= pdmc_pkg::RST_OSC_SELECT;
		end else if (wr_osc) begin
			oscillator_select_control <= bus.wdata;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			cpu_clock_divider_control <= pdmc_pkg::RST_CLK_DIV;
		end else if (wr_div) begin
			cpu_clock_divider_control <= bus.wdata;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			basic_timer_control <= pdmc_pkg::RST_BT_CTRL;
		end else if (wr_bt) begin
			basic_timer_control <= bus.wdata;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			stop_key_register <= pdmc_pkg::RST_STOP_KEY;
		end else if (wr_key) begin
			stop_key_register <= bus.wdata;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			interrupt_mask_register <= pdmc_pkg::RST_IRQ_MASK;
		end else if (wr_mask) begin
			interrupt_mask_register <= bus.wdata;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			stab_count <= 8'h00;
		end else if (stop_release) begin
			stab_count <= stab_cycles(stab_sel);
		end else if (state == pdmc_pkg::PDMC_WAKE) begin
			stab_count <= stab_count - 8'h01;
		end
	end

	// The count stops only in Stop mode, not on the main oscillator stop bit, and restarts from zero on a stop release
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			basic_timer_count <= 8'h00;
		end else if (stop_release) begin
			basic_timer_count <= 8'h00;
		end else if (state != pdmc_pkg::PDMC_STOP) begin
			basic_timer_count <= basic_timer_count + 8'h01;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			div_count <= 4'h0;
			cpu_tick_out <= 1'b0;
		end else begin
			div_count <= (div_wrap || cpu_halted) ? 4'h0 : div_count + 4'h1;
			cpu_tick_out <= next_cpu_tick;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			io_dir_latched <= 8'h00;
		end else if (state == pdmc_pkg::PDMC_RUN) begin
			io_dir_latched <= io_dir_in;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			first_cycle <= 1'b1;
		end else begin
			first_cycle <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 8'h00;
		end else begin
			reg_rdata_out <= next_rdata;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			cpu_clk_en_out <= 1'b1;
			periph_clk_en_out <= 1'b1;
			idle_periph_clk_en_out <= 1'b1;
			main_osc_run_out <= 1'b1;
			sub_osc_run_out <= 1'b1;
			watch_lcd_en_out <= 1'b1;
		end else begin
			cpu_clk_en_out <= gate.cpu_clk_en;
			periph_clk_en_out <= gate.periph_clk_en;
			idle_periph_clk_en_out <= gate.idle_periph_clk_en;
			main_osc_run_out <= gate.main_osc_run;
			sub_osc_run_out <= gate.sub_osc_run;
			watch_lcd_en_out <= gate.watch_lcd_en;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			regfile_hold_out <= 1'b0;
		end else begin
			regfile_hold_out <= next_regfile_hold;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			io_dir_out <= 8'h00;
			io_dir_hold_out <= 1'b0;
		end else begin
			io_dir_out <= next_io_dir;
			io_dir_hold_out <= next_io_dir_hold;
		end
	end

	// One-cycle request to the core to take the waking interrupt before resuming
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			wake_irq_out <= 1'b0;
		end else begin
			wake_irq_out <= next_wake_irq;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			fetch_reset_out <= 1'b1;
			fetch_addr_out <= pdmc_pkg::RESET_VECTOR;
		end else begin
			fetch_reset_out <= first_cycle;
			fetch_addr_out <= pdmc_pkg::RESET_VECTOR;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			mode_out <= pdmc_pkg::PDMC_RUN;
		end else begin
			mode_out <= next_state;
		end
	end
endmodule
`default_nettype wire

/* bench/pdmc_props.sv */
// Purpose: Port-level assertions for the power-down mode controller
// Assumes: One clock, synchronous active-low reset
// Notes: Key and mask registers are not visible at the ports; the bench covers them
`timescale 1ns/1ps
`default_nettype none
module pdmc_props (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic opcode_valid_in,
	input wire logic [7:0] opcode_in,
	input wire logic watch_sub_clk_in,
	input wire logic cpu_clk_en_out,
	input wire logic periph_clk_en_out,
	input wire logic idle_periph_clk_en_out,
	input wire logic main_osc_run_out,
	input wire logic watch_lcd_en_out,
	input wire logic regfile_hold_out,
	input wire logic [7:0] io_dir_out,
	input wire logic io_dir_hold_out,
	input wire logic wake_irq_out,
	input wire logic fetch_reset_out,
	input wire logic [15:0] fetch_addr_out,
	input wire logic [1:0] mode_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence in_stop_s;
		mode_out == pdmc_pkg::PDMC_STOP;
	endsequence
	sequence idle_exit_s;
		mode_out == pdmc_pkg::PDMC_IDLE ##1 mode_out != pdmc_pkg::PDMC_IDLE;
	endsequence
	// Longest stabilisation is 128 cycles, so the bound leaves a small margin
	sequence back_to_run_s;
		##[1:140] (wake_irq_out && mode_out == pdmc_pkg::PDMC_RUN && cpu_clk_en_out);
	endsequence
	stop_halt_a: assert property (in_stop_s |-> !cpu_clk_en_out && !main_osc_run_out && !periph_clk_en_out && regfile_hold_out)
		else $error("clocks running or register file free in stop");
	watch_run_a: assert property (mode_out == pdmc_pkg::PDMC_STOP && $past(mode_out) == pdmc_pkg::PDMC_STOP && $past(watch_sub_clk_in) |-> watch_lcd_en_out)
		else $error("watch timer halted in stop");
	idle_entry_a: assert property (opcode_valid_in && opcode_in == pdmc_pkg::OPC_IDLE && mode_out == pdmc_pkg::PDMC_RUN |=> mode_out == pdmc_pkg::PDMC_IDLE)
		else $error("idle opcode did not enter idle");
	idle_gate_a: assert property (mode_out == pdmc_pkg::PDMC_IDLE |-> !cpu_clk_en_out && !periph_clk_en_out && idle_periph_clk_en_out && io_dir_hold_out)
		else $error("wrong clock gating in idle");
	dir_freeze_a: assert property (mode_out == pdmc_pkg::PDMC_IDLE && $past(mode_out) == pdmc_pkg::PDMC_IDLE |-> $stable(io_dir_out))
		else $error("pin direction changed in idle");
	idle_wake_a: assert property (idle_exit_s |-> wake_irq_out && cpu_clk_en_out)
		else $error("idle ended without a wake pulse");
	wake_return_a: assert property (mode_out == pdmc_pkg::PDMC_WAKE |-> back_to_run_s)
		else $error("stabilisation did not end in run");
	pulse_once_a: assert property (wake_irq_out |=> !wake_irq_out)
		else $error("wake pulse longer than one cycle");
	fetch_vector_a: assert property ($rose(rst_n_in) |-> fetch_reset_out && fetch_addr_out == pdmc_pkg::RESET_VECTOR)
		else $error("fetch not from reset vector");
endmodule
bind pdmc_controller pdmc_props pdmc_props_inst (.core_clk_in, .rst_n_in, .opcode_valid_in, .opcode_in,
	.watch_sub_clk_in, .cpu_clk_en_out, .periph_clk_en_out, .idle_periph_clk_en_out,
	.main_osc_run_out, .watch_lcd_en_out, .regfile_hold_out, .io_dir_out, .io_dir_hold_out, .wake_irq_out,
	.fetch_reset_out, .fetch_addr_out, .mode_out);
`default_nettype wire

/* bench/pdmc_cpu_model.sv */
// Purpose: CPU core model that executes stop and idle instructions
// Assumes: Bench requests one instruction at a time
// Notes: The opcode bus toggles when idle, so a stale value is never mistaken for a fetch
`timescale 1ns/1ps
`default_nettype none
module pdmc_cpu_model #(
	parameter logic [7:0] NOP_OP = 8'h00
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic issue_in,
	input wire logic [7:0] op_in,
	output logic valid_out,
	output logic [7:0] op_out
);
	logic [1:0] nop_left;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			valid_out <= 1'b0;
			op_out <= NOP_OP;
			nop_left <= 2'h0;
		end else if (issue_in) begin
			valid_out <= 1'b1;
			op_out <= op_in;
			nop_left <= (op_in == pdmc_pkg::OPC_STOP) ? 2'h3 : 2'h0;
		end else if (nop_left != 2'h0) begin
			valid_out <= 1'b1;
			op_out <= NOP_OP;
			nop_left <= nop_left - 2'h1;
		end else begin
			valid_out <= 1'b0;
			op_out <= ~op_out;
		end
	end
endmodule
`default_nettype wire

/* bench/tb.sv */
// Purpose: Self-checking bench for the power-down mode controller
// Assumes: Bench plays software and interrupt sources, the model plays the CPU
// Notes: The longest stabilisation select is used so wake timing is visible
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	pdmc_pkg::pdmc_bus_t bus = '0;
	logic issue = 1'b0;
	logic [7:0] op = 8'h00;
	logic [7:0] ext_irq = 8'h00;
	logic watch_irq = 1'b0;
	logic int_irq = 1'b0;
	logic watch_sub = 1'b0;
	logic [7:0] dir = 8'h00;
	logic valid, cpu_en, tick, wake, main_run, sub_run, watch_en;
	logic [7:0] opc, rdata, dir_q;
	logic [1:0] mode;
	int failures = 0;
	int n_checks = 0;
	always #5 clk = ~clk;
	pdmc_cpu_model pdmc_cpu_model_inst (.clk_in(clk), .rst_n_in(rst_n), .issue_in(issue), .op_in(op),
		.valid_out(valid), .op_out(opc));
	pdmc_controller pdmc_controller_inst (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(bus.addr),
		.reg_wdata_in(bus.wdata), .reg_wr_in(bus.wr), .reg_rd_in(bus.rd), .reg_rdata_unused_in(8'h00),
		.opcode_valid_in(valid), .opcode_in(opc), .ext_irq_in(ext_irq), .watch_irq_in(watch_irq),
		.internal_irq_in(int_irq), .watch_sub_clk_in(watch_sub), .io_dir_in(dir), .reg_rdata_out(rdata),
		.cpu_clk_en_out(cpu_en), .periph_clk_en_out(), .idle_periph_clk_en_out(), .main_osc_run_out(main_run),
		.sub_osc_run_out(sub_run), .watch_lcd_en_out(watch_en), .cpu_tick_out(tick), .regfile_hold_out(),
		.io_dir_out(dir_q), .io_dir_hold_out(), .wake_irq_out(wake), .fetch_reset_out(), .fetch_addr_out(),
		.mode_out(mode));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	// Leaves three edges so the model's fetch and the mode change have landed
	task automatic exec(input logic [7:0] o);
		@(posedge clk);
		issue <= 1'b1;
		op <= o;
		@(posedge clk);
		issue <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic wait_for(input logic sig_is_wake, input int bound, output int i);
		for (i = 0; i < bound && (sig_is_wake ? wake : tick) !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == bound) begin
			failures++;
			end_of_test();
		end
	endtask
	task automatic tick_gap(output int n);
		int i;
		wait_for(1'b0, 40, i);
		@(posedge clk);
		#1;
		wait_for(1'b0, 40, n);
		n++;
	endtask
	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		ext_irq <= 8'h00;
		watch_irq <= 1'b0;
		int_irq <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	task automatic t_regs();
		rd_chk(8'hd4, 8'h00);
		rd_chk(8'hdc, 8'h00);
		rd_chk(pdmc_pkg::ADDR_STOP_KEY, 8'h00);
		wr(8'hff, 8'h33);
		rd_chk(8'hff, 8'h00);
		wr(8'hd3, 8'h0c);
		rd_chk(8'hd3, 8'h0c);
		chk({6'h0, main_run, sub_run}, 8'h00);
		wr(8'hd3, 8'h00);
		rd_chk(8'hd3, 8'h00);
		chk({6'h0, main_run, sub_run}, 8'h03);
		$display("test regs done");
	endtask
	task automatic t_div();
		int n;
		int per[4] = '{16, 8, 2, 1};
		for (int k = 0; k < 4; k++) begin
			wr(8'hd4, 8'(k << 3));
			tick_gap(n);
			tick_gap(n);
			chk(8'(n), 8'(per[k]));
		end
		$display("test divider done");
	endtask
	task automatic t_nokey();
		wr(pdmc_pkg::ADDR_STOP_KEY, 8'h5a);
		exec(pdmc_pkg::OPC_STOP);
		chk({5'h0, cpu_en, mode}, 8'h04);
		$display("test stop without key done");
	endtask
	task automatic t_stop(input logic use_watch);
		int n;
		wr(8'hdc, 8'h0c);
		wr(8'hd4, 8'h10);
		wr(pdmc_pkg::ADDR_IRQ_MASK, 8'h01);
		watch_sub <= 1'b1;
		wr(pdmc_pkg::ADDR_STOP_KEY, 8'ha5);
		exec(pdmc_pkg::OPC_STOP);
		chk({4'h0, cpu_en, main_run, mode}, 8'h01);
		repeat (20) @(posedge clk);
		#1 chk({5'h0, watch_en, mode}, 8'h05);
		if (use_watch)
			watch_irq <= 1'b1;
		else
			ext_irq <= 8'h01;
		wait_for(1'b1, 300, n);
		chk(8'(n >= 128), 8'h01);
		chk({5'h0, cpu_en, mode}, 8'h04);
		@(posedge clk);
		ext_irq <= 8'h00;
		watch_irq <= 1'b0;
		rd_chk(8'hd4, 8'h10);
		rd_chk(8'hdc, 8'h0c);
		wr(pdmc_pkg::ADDR_STOP_KEY, 8'h00);
		$display("test stop wake done");
	endtask
	task automatic t_subsys();
		wr(8'hd3, 8'h01);
		wr(pdmc_pkg::ADDR_STOP_KEY, 8'ha5);
		exec(pdmc_pkg::OPC_STOP);
		ext_irq <= 8'h01;
		watch_irq <= 1'b1;
		repeat (40) @(posedge clk);
		#1 chk({6'h0, mode}, 8'h01);
		do_reset();
		rd_chk(8'hd3, 8'h00);
		rd_chk(8'hd4, 8'h00);
		$display("test sub clock stop done");
	endtask
	task automatic t_idle();
		int n;
		wr(8'hd4, 8'h18);
		wr(pdmc_pkg::ADDR_IRQ_MASK, 8'h02);
		dir <= 8'h3c;
		exec(pdmc_pkg::OPC_IDLE);
		chk({5'h0, cpu_en, mode}, 8'h02);
		rd_chk(pdmc_pkg::ADDR_STATUS, 8'h02);
		dir <= 8'hc3;
		ext_irq <= 8'hfd;
		repeat (20) @(posedge clk);
		#1 chk(dir_q, 8'h3c);
		@(posedge clk);
		ext_irq <= 8'h00;
		int_irq <= 1'b1;
		wait_for(1'b1, 20, n);
		@(posedge clk);
		int_irq <= 1'b0;
		rd_chk(8'hd4, 8'h18);
		wr(pdmc_pkg::ADDR_IRQ_MASK, 8'h00);
		exec(pdmc_pkg::OPC_IDLE);
		ext_irq <= 8'hff;
		int_irq <= 1'b1;
		watch_irq <= 1'b1;
		repeat (20) @(posedge clk);
		#1 chk({6'h0, mode}, 8'h02);
		do_reset();
		rd_chk(8'hd4, 8'h00);
		tick_gap(n);
		chk(8'(n), 8'd16);
		$display("test idle done");
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_regs();
		t_div();
		t_nokey();
		t_stop(1'b0);
		t_stop(1'b1);
		t_subsys();
		t_idle();
		end_of_test();
	end
endmodule
`default_nettype wire
